// >>> src/i2cm_pkg.sv
package i2cm_pkg;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W      = 3;
    localparam int PTR_W      = 2;
    localparam int DATA_W     = 8;
    localparam int DIV_W      = 8;
    localparam int FLT_W      = 4;
    localparam int TMO_W      = 16;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IEN    = 8'h08;
    localparam logic [7:0] ADDR_WMARK  = 8'h0C;
    localparam logic [7:0] ADDR_FCNT   = 8'h10;
    localparam logic [7:0] ADDR_TIMING = 8'h14;
    localparam logic [7:0] ADDR_TMO    = 8'h18;
    localparam logic [7:0] ADDR_MATCH  = 8'h1C;
    localparam logic [7:0] ADDR_TXDATA = 8'h20;
    localparam logic [7:0] ADDR_RXDATA = 8'h24;

    localparam int CTRL_EN    = 0;
    localparam int CTRL_SWRST = 1;
    localparam int CTRL_TXDMA = 2;
    localparam int CTRL_RXDMA = 3;

    localparam int ST_TXSPACE = 0;
    localparam int ST_RXAVAIL = 1;
    localparam int ST_PKTEND  = 8;
    localparam int ST_STOP    = 9;
    localparam int ST_NACK    = 10;
    localparam int ST_ARB     = 11;
    localparam int ST_QERR    = 12;
    localparam int ST_STUCK   = 13;
    localparam int ST_MATCH   = 14;
    localparam int ST_CACT    = 24;
    localparam int ST_BUSOCC  = 25;
    localparam int ST_W       = 26;

    localparam logic [ST_W-1:0] W1C_MASK = 26'h0007F00;
    localparam logic [ST_W-1:0] IEN_MASK = 26'h0007F03;

    localparam int WM_RX_LSB  = 16;
    localparam int FCNT_RX_LSB = 16;
    localparam int TIM_FLT_SCL_LSB = 8;
    localparam int TIM_FLT_SDA_LSB = 12;
    localparam int TMO_IDLE_LSB = 16;

    localparam logic [DIV_W-1:0] DIV_RST = 8'h3F;
    localparam logic [31:0]      ERR_DATA = 32'h00000000;

    typedef enum logic [2:0] {
        I2CM_IDLE  = 3'b000,
        I2CM_START = 3'b001,
        I2CM_BIT   = 3'b010,
        I2CM_ACK   = 3'b011,
        I2CM_STOP  = 3'b100
    } i2cm_state_t;
endpackage : i2cm_pkg

// >>> src/i2cm_ctrl.sv
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R01] Transmit space flag set while transmit count is at or below its watermark.
// [R02] Receive available flag set while receive count exceeds its watermark.
// [R03] Watermark writes at or above FIFO depth are truncated to index width.
// [R04] Only packet end, stop, NACK, arbitration, queue error, stuck, match clear.
// [R05] Each flag but both busy flags has a readable enable; enabled set flags interrupt.
// [R06] Transmit and receive DMA requests have separate enables.
// [R07] Transmit and receive data registers sit at fixed addresses for DMA.
// [R08] Both FIFO word counts are readable.
// [R09] Software reset returns master logic and configuration to reset values.
// [R10] Master enable bit starts or stops master operation.
// [R11] Software disables the master before changing divider settings.
// [R12] Disabling the master during a transfer aborts it.
// [R13] Divider, glitch filters and timeouts count functional clock cycles.
// [R14] Line stuck low flag set when SCL or SDA low longer than timeout.
// [R15] NACK flag set when slave answers a transmitted byte with not-acknowledge.
// [R16] Writing one clears a clearable flag; zero has no effect.
// [R17] Queue error set on transmit underrun or receive overrun.
module i2cm_ctrl (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [7:0]            i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_scl,
    output logic                       o_scl_oe,
    output logic                       o_sda,
    output logic                       o_sda_oe,
    output logic                       o_irq,
    output logic                       o_tx_dma_req,
    output logic                       o_rx_dma_req
);
    import i2cm_pkg::*;

    typedef struct packed {
        logic [31:0]                  rdat;
        logic                         ack;
        logic                         en;
        logic                         txdma;
        logic                         rxdma;
        logic [ST_W-1:0]              st;
        logic [ST_W-1:0]              ien;
        logic [PTR_W-1:0]             txwm;
        logic [PTR_W-1:0]             rxwm;
        logic [DIV_W-1:0]             div;
        logic [FLT_W-1:0]             flt_scl;
        logic [FLT_W-1:0]             flt_sda;
        logic [TMO_W-1:0]             tmo_low;
        logic [TMO_W-1:0]             tmo_idle;
        logic [DATA_W-1:0]            match;
        logic [FIFO_DEPTH*DATA_W-1:0] txq;
        logic [CNT_W-1:0]             txcnt;
        logic [FIFO_DEPTH*DATA_W-1:0] rxq;
        logic [CNT_W-1:0]             rxcnt;
        logic [2:0]                   scl_s;
        logic [2:0]                   sda_s;
        logic                         scl_f;
        logic                         sda_f;
        logic [FLT_W-1:0]             scl_fc;
        logic [FLT_W-1:0]             sda_fc;
        logic [TMO_W-1:0]             lowc;
        logic [TMO_W-1:0]             idlec;
        logic                         busocc;
        i2cm_state_t                  fsm;
        logic [DIV_W-1:0]             divc;
        logic [1:0]                   ph;
        logic [3:0]                   bitn;
        logic [DATA_W-1:0]            sh;
        logic                         rd;
        logic                         scl_o;
        logic                         sda_o;
    } i2cm_state_s_t;

    i2cm_state_s_t st_r;
    i2cm_state_s_t st_nxt;

    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [3:0] BITS    = 4'h8;

    logic acc;
    logic wr;
    logic tick;
    logic txpop;
    logic rxpush;
    logic [ST_W-1:0] ev;
    logic [DATA_W-1:0] rxbyte;

    always_comb begin
        acc    = i_wb_cyc && i_wb_stb && !st_r.ack;
        wr     = acc && i_wb_we && i_wb_sel[0];
        tick   = (st_r.divc == '0);
        txpop  = 1'b0;
        rxpush = 1'b0;
        rxbyte = {st_r.sh[DATA_W-2:0], st_r.sda_f};
        ev     = '0;
        st_nxt = st_r;
        st_nxt.ack = acc;
        st_nxt.scl_s = {st_r.scl_s[1:0], i_scl};
        st_nxt.sda_s = {st_r.sda_s[1:0], i_sda};
        // Pins count after the second and third stage agree, then filter.
        if (st_r.scl_s[2] == st_r.scl_s[1] && st_r.scl_s[1] != st_r.scl_f) begin
            st_nxt.scl_fc = st_r.scl_fc + 1'b1; // see [R13]
            if (st_r.scl_fc >= st_r.flt_scl) begin
                st_nxt.scl_f  = st_r.scl_s[1];
                st_nxt.scl_fc = '0;
            end
        end else begin
            st_nxt.scl_fc = '0;
        end
        if (st_r.sda_s[2] == st_r.sda_s[1] && st_r.sda_s[1] != st_r.sda_f) begin
            st_nxt.sda_fc = st_r.sda_fc + 1'b1; // see [R13]
            if (st_r.sda_fc >= st_r.flt_sda) begin
                st_nxt.sda_f  = st_r.sda_s[1];
                st_nxt.sda_fc = '0;
            end
        end else begin
            st_nxt.sda_fc = '0;
        end
        // Start and stop on the bus set or clear the occupied indication.
        if (st_r.scl_f && st_r.sda_f && !st_nxt.sda_f) begin
            st_nxt.busocc = 1'b1;
        end
        if (st_r.scl_f && !st_r.sda_f && st_nxt.sda_f) begin
            st_nxt.busocc = 1'b0;
            ev[ST_STOP]   = 1'b1;
        end
        if (st_r.scl_f && st_r.sda_f) begin
            st_nxt.idlec = st_r.idlec + 1'b1; // see [R13]
            if (st_r.tmo_idle != '0 && st_r.idlec >= st_r.tmo_idle) begin
                st_nxt.busocc = 1'b0;
            end
        end else begin
            st_nxt.idlec = '0;
        end
        if (!st_r.scl_f || !st_r.sda_f) begin
            if (st_r.lowc != {TMO_W{1'b1}}) begin
                st_nxt.lowc = st_r.lowc + 1'b1;
            end
            if (st_r.tmo_low != '0 && st_r.lowc == st_r.tmo_low) begin
                ev[ST_STUCK] = 1'b1; // see [R14]
            end
        end else begin
            st_nxt.lowc = '0;
        end
        // Byte engine: four divider phases per bit; a zero divider ticks every cycle.
        st_nxt.divc = tick ? st_r.div : st_r.divc - 1'b1; // see [R13]
        unique case (st_r.fsm)
            I2CM_IDLE: begin
                st_nxt.scl_o = 1'b1;
                st_nxt.sda_o = 1'b1;
                if (st_r.en && tick && st_r.txcnt != '0 && !st_r.busocc) begin
                    st_nxt.fsm = I2CM_START;
                    st_nxt.ph  = '0;
                end
            end
            I2CM_START: begin
                if (tick) begin
                    st_nxt.ph = st_r.ph + 1'b1;
                    st_nxt.sda_o = 1'b0;
                    if (st_r.ph == PH_LAST) begin
                        st_nxt.scl_o = 1'b0;
                        st_nxt.sh    = st_r.txq[DATA_W-1:0];
                        st_nxt.rd    = st_r.txq[0];
                        st_nxt.bitn  = '0;
                        txpop        = 1'b1;
                        st_nxt.fsm   = I2CM_BIT;
                    end
                end
            end
            I2CM_BIT: begin
                if (tick) begin
                    st_nxt.ph = st_r.ph + 1'b1;
                    unique case (st_r.ph)
                        2'h0: st_nxt.sda_o = st_r.sh[DATA_W-1];
                        2'h1: st_nxt.scl_o = 1'b1;
                        2'h2: begin
                            if (st_r.sda_o && !st_r.sda_f) begin
                                ev[ST_ARB] = 1'b1;
                                st_nxt.fsm = I2CM_IDLE;
                            end
                        end
                        2'h3: begin
                            st_nxt.scl_o = 1'b0;
                            st_nxt.sh    = rxbyte;
                            st_nxt.bitn  = st_r.bitn + 1'b1;
                            if (st_r.bitn == BITS - 1'b1) begin
                                st_nxt.fsm = I2CM_ACK;
                            end
                        end
                    endcase
                end
            end
            I2CM_ACK: begin
                if (tick) begin
                    st_nxt.ph = st_r.ph + 1'b1;
                    unique case (st_r.ph)
                        2'h0: st_nxt.sda_o = 1'b1;
                        2'h1: st_nxt.scl_o = 1'b1;
                        2'h2: ;
                        2'h3: begin
                            st_nxt.scl_o = 1'b0;
                            if (st_r.sda_f) begin
                                ev[ST_NACK] = 1'b1; // see [R15]
                                st_nxt.fsm  = I2CM_STOP;
                            end else if (st_r.txcnt != '0) begin
                                st_nxt.sh   = st_r.txq[DATA_W-1:0];
                                txpop       = 1'b1;
                                st_nxt.bitn = '0;
                                st_nxt.fsm  = I2CM_BIT;
                            end else begin
                                st_nxt.fsm  = I2CM_STOP;
                            end
                            if (st_r.sh == st_r.match) begin
                                ev[ST_MATCH] = 1'b1;
                            end
                        end
                    endcase
                end
            end
            I2CM_STOP: begin
                if (tick) begin
                    st_nxt.ph = st_r.ph + 1'b1;
                    unique case (st_r.ph)
                        2'h0: st_nxt.sda_o = 1'b0;
                        2'h1: st_nxt.scl_o = 1'b1;
                        2'h2: st_nxt.sda_o = 1'b1;
                        2'h3: begin
                            ev[ST_PKTEND] = 1'b1;
                            st_nxt.fsm    = I2CM_IDLE;
                        end
                    endcase
                end
            end
            default: st_nxt.fsm = I2CM_IDLE;
        endcase
        // Each received byte goes to the receive queue; full means overrun.
        if (st_r.fsm == I2CM_ACK && tick && st_r.ph == PH_LAST) begin
            if (st_r.rxcnt == CNT_W'(FIFO_DEPTH)) begin
                ev[ST_QERR] = 1'b1; // see [R17]
            end else begin
                rxpush = 1'b1;
            end
        end
        if (!st_r.en) begin
            st_nxt.fsm   = I2CM_IDLE; // see [R10] [R12]
            st_nxt.scl_o = 1'b1;
            st_nxt.sda_o = 1'b1;
        end
        // Register writes.
        if (wr) begin
            unique case (i_wb_adr)
                ADDR_CTRL: begin
                    st_nxt.en    = i_wb_dat[CTRL_EN];    // see [R10]
                    st_nxt.txdma = i_wb_dat[CTRL_TXDMA]; // see [R06]
                    st_nxt.rxdma = i_wb_dat[CTRL_RXDMA]; // see [R06]
                end
                ADDR_IEN: st_nxt.ien = i_wb_dat[ST_W-1:0] & IEN_MASK; // see [R05]
                ADDR_WMARK: begin
                    st_nxt.txwm = i_wb_dat[PTR_W-1:0]; // see [R03]
                    st_nxt.rxwm = i_wb_dat[WM_RX_LSB +: PTR_W]; // see [R03]
                end
                ADDR_TIMING: begin
                    st_nxt.div     = i_wb_dat[DIV_W-1:0]; // see [R11]
                    st_nxt.flt_scl = i_wb_dat[TIM_FLT_SCL_LSB +: FLT_W];
                    st_nxt.flt_sda = i_wb_dat[TIM_FLT_SDA_LSB +: FLT_W];
                end
                ADDR_TMO: begin
                    st_nxt.tmo_low  = i_wb_dat[TMO_W-1:0];
                    st_nxt.tmo_idle = i_wb_dat[TMO_IDLE_LSB +: TMO_W];
                end
                ADDR_MATCH: st_nxt.match = i_wb_dat[DATA_W-1:0];
                default: ;
            endcase
        end
        // Transmit queue: pop then push, both aligned to slot zero.
        if (txpop) begin
            st_nxt.txq   = st_r.txq >> DATA_W;
            st_nxt.txcnt = st_r.txcnt - 1'b1;
        end
        if (wr && i_wb_adr == ADDR_TXDATA) begin // see [R07]
            if (st_nxt.txcnt != CNT_W'(FIFO_DEPTH)) begin
                st_nxt.txq[st_nxt.txcnt[PTR_W-1:0]*DATA_W +: DATA_W] =
                    i_wb_dat[DATA_W-1:0];
                st_nxt.txcnt = st_nxt.txcnt + 1'b1;
            end
        end
        // Popping an empty receive queue leaves it unchanged and raises no flag.
        if (acc && !i_wb_we && i_wb_adr == ADDR_RXDATA) begin // see [R07]
            if (st_r.rxcnt != '0) begin
                st_nxt.rxq   = st_r.rxq >> DATA_W;
                st_nxt.rxcnt = st_r.rxcnt - 1'b1;
            end
        end
        if (rxpush) begin
            st_nxt.rxq[st_nxt.rxcnt[PTR_W-1:0]*DATA_W +: DATA_W] = st_r.sh;
            st_nxt.rxcnt = st_nxt.rxcnt + 1'b1;
        end
        if (st_r.fsm == I2CM_ACK && tick && st_r.ph == PH_LAST && !st_r.sda_f
            && st_r.txcnt == '0 && st_r.en) begin
            ev[ST_QERR] = 1'b1; // see [R17]
        end
        // Sticky flags: the set wins over a write-one clear.
        if (wr && i_wb_adr == ADDR_STATUS) begin
            st_nxt.st = st_r.st & ~(i_wb_dat[ST_W-1:0] & W1C_MASK); // see [R04] [R16]
        end
        st_nxt.st = st_nxt.st | (ev & W1C_MASK);
        st_nxt.st[ST_TXSPACE] = st_nxt.txcnt <= {1'b0, st_nxt.txwm}; // see [R01]
        st_nxt.st[ST_RXAVAIL] = st_nxt.rxcnt > {1'b0, st_nxt.rxwm};  // see [R02]
        st_nxt.st[ST_CACT]    = st_nxt.fsm != I2CM_IDLE;
        st_nxt.st[ST_BUSOCC]  = st_nxt.busocc;
        // Register reads.
        st_nxt.rdat = ERR_DATA;
        if (acc && !i_wb_we) begin
            unique case (i_wb_adr)
                ADDR_CTRL: begin
                    st_nxt.rdat[CTRL_EN]    = st_r.en;
                    st_nxt.rdat[CTRL_TXDMA] = st_r.txdma;
                    st_nxt.rdat[CTRL_RXDMA] = st_r.rxdma;
                end
                ADDR_STATUS: st_nxt.rdat[ST_W-1:0] = st_r.st;
                ADDR_IEN:    st_nxt.rdat[ST_W-1:0] = st_r.ien; // see [R05]
                ADDR_WMARK: begin
                    st_nxt.rdat[PTR_W-1:0]             = st_r.txwm;
                    st_nxt.rdat[WM_RX_LSB +: PTR_W]    = st_r.rxwm;
                end
                ADDR_FCNT: begin
                    st_nxt.rdat[CNT_W-1:0]             = st_r.txcnt; // see [R08]
                    st_nxt.rdat[FCNT_RX_LSB +: CNT_W]  = st_r.rxcnt; // see [R08]
                end
                ADDR_TIMING: begin
                    st_nxt.rdat[DIV_W-1:0]                 = st_r.div;
                    st_nxt.rdat[TIM_FLT_SCL_LSB +: FLT_W]  = st_r.flt_scl;
                    st_nxt.rdat[TIM_FLT_SDA_LSB +: FLT_W]  = st_r.flt_sda;
                end
                ADDR_TMO: begin
                    st_nxt.rdat[TMO_W-1:0]              = st_r.tmo_low;
                    st_nxt.rdat[TMO_IDLE_LSB +: TMO_W]  = st_r.tmo_idle;
                end
                ADDR_MATCH:  st_nxt.rdat[DATA_W-1:0] = st_r.match;
                ADDR_RXDATA: st_nxt.rdat[DATA_W-1:0] = st_r.rxq[DATA_W-1:0];
                default: ;
            endcase
        end
        // Software reset restores everything except the bus answer itself.
        if (wr && i_wb_adr == ADDR_CTRL && i_wb_dat[CTRL_SWRST]) begin
            st_nxt       = '0; // see [R09]
            st_nxt.ack   = 1'b1;
            st_nxt.div   = DIV_RST;
            st_nxt.scl_o = 1'b1;
            st_nxt.sda_o = 1'b1;
            st_nxt.scl_f = 1'b1;
            st_nxt.sda_f = 1'b1;
            st_nxt.scl_s = 3'h7;
            st_nxt.sda_s = 3'h7;
            st_nxt.st[ST_TXSPACE] = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r                  <= '0;
            st_r.div              <= DIV_RST;
            st_r.scl_o            <= 1'b1;
            st_r.sda_o            <= 1'b1;
            st_r.scl_f            <= 1'b1;
            st_r.sda_f            <= 1'b1;
            st_r.scl_s            <= 3'h7;
            st_r.sda_s            <= 3'h7;
            st_r.st[ST_TXSPACE]   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_wb_dat     = st_r.rdat;
    assign o_wb_ack     = st_r.ack;
    assign o_irq        = |(st_r.st & st_r.ien); // see [R05]
    assign o_tx_dma_req = st_r.txdma && st_r.st[ST_TXSPACE]; // see [R06]
    assign o_rx_dma_req = st_r.rxdma && st_r.st[ST_RXAVAIL]; // see [R06]
    assign o_scl        = 1'b0;
    assign o_sda        = 1'b0;
    assign o_scl_oe     = !st_r.scl_o;
    assign o_sda_oe     = !st_r.sda_o;
endmodule : i2cm_ctrl
`default_nettype wire

// >>> test/i2cm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module i2cm_chk (
    input wire logic        i_sys_clk,
    input wire logic        i_nrst,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_scl_oe,
    input wire logic        o_sda_oe,
    input wire logic        o_irq,
    input wire logic        o_tx_dma_req
);
    import i2cm_pkg::*;
    logic rd;
    logic wc;
    assign rd = o_wb_ack && !i_wb_we;
    assign wc = o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == ADDR_CTRL;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered in one cycle");
    a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data outside ack");
    a_unmapped_zero: assert property (rd && i_wb_adr > ADDR_RXDATA |-> o_wb_dat == ERR_DATA)
        else $error("unmapped read not zero");
    a_status_layout: assert property (rd && i_wb_adr == ADDR_STATUS |-> (o_wb_dat & 32'hFCFF80FC) == 32'h0)
        else $error("status reserved bits set");
    a_ien_layout: assert property (rd && i_wb_adr == ADDR_IEN |-> (o_wb_dat & 32'hFFFF80FC) == 32'h0)
        else $error("enable bit set on busy or reserved place");
    a_wmark_trunc: assert property (rd && i_wb_adr == ADDR_WMARK |-> (o_wb_dat & 32'hFFFCFFFC) == 32'h0)
        else $error("watermark not truncated");
    a_fcnt_range: assert property (rd && i_wb_adr == ADDR_FCNT |-> o_wb_dat[2:0] <= 3'h4 && o_wb_dat[18:16] <= 3'h4)
        else $error("fifo count above depth");
    a_swrst_reads0: assert property (rd && i_wb_adr == ADDR_CTRL |-> o_wb_dat[31:4] == 28'h0 && !o_wb_dat[CTRL_SWRST])
        else $error("control reads back soft reset");
    a_abort_release: assert property (wc && !i_wb_dat[CTRL_EN] |-> ##[0:3] !o_scl_oe && !o_sda_oe)
        else $error("lines still driven after disable");
    a_dma_off: assert property (wc && !i_wb_dat[CTRL_TXDMA] |-> ##[0:2] !o_tx_dma_req)
        else $error("tx dma request while disabled");
    a_irq_masked: assert property (o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == ADDR_IEN && i_wb_dat == 32'h0 |-> ##[1:2] !o_irq)
        else $error("interrupt with all enables off");
endmodule : i2cm_chk
bind i2cm_ctrl i2cm_chk i_i2cm_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_scl_oe(o_scl_oe),
    .o_sda_oe(o_sda_oe), .o_irq(o_irq), .o_tx_dma_req(o_tx_dma_req));
`default_nettype wire

// >>> test/i2cm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2cm_slave_model (
    input  wire logic i_scl,
    input  wire logic i_sda,
    input  wire logic i_ack_en,
    input  wire logic i_hold_low,
    output logic      o_sda_oe
);
    int   bits;
    logic ack_r;
    initial ack_r = 1'b0;
    always @(negedge i_sda) if (i_scl) bits = 0;
    always @(posedge i_scl) bits = bits + 1;
    always @(negedge i_scl) begin
        ack_r = (bits == 8) && i_ack_en;
        if (bits == 9) bits = 0;
    end
    // Holding SDA low stands for a hung device on the bus.
    assign o_sda_oe = ack_r || i_hold_low;
endmodule : i2cm_slave_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import i2cm_pkg::*;
    logic        i_sys_clk, i_nrst, i_wb_cyc, i_wb_stb, i_wb_we;
    logic [7:0]  i_wb_adr;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, rd_q, seed;
    logic        o_wb_ack, o_scl, o_scl_oe, o_sda, o_sda_oe, o_irq;
    logic        o_tx_dma_req, o_rx_dma_req, slv_oe, ack_en, hold_low;
    // Pull-ups: a released line reads high.
    wire logic   scl_w = !o_scl_oe;
    wire logic   sda_w = !(o_sda_oe || slv_oe);
    int          fail_count, checked;
    i2cm_ctrl i_i2cm_ctrl (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_scl(scl_w),
        .i_sda(sda_w), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .o_sda(o_sda),
        .o_sda_oe(o_sda_oe), .o_irq(o_irq), .o_tx_dma_req(o_tx_dma_req),
        .o_rx_dma_req(o_rx_dma_req));
    i2cm_slave_model i_i2cm_slave_model (.i_scl(scl_w), .i_sda(sda_w),
        .i_ack_en(ack_en), .i_hold_low(hold_low), .o_sda_oe(slv_oe));
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] wm(input logic [31:0] d);
        return {14'h0, d[17:16], 14'h0, d[1:0]};
    endfunction : wm
    task automatic report_and_stop;
        $display("mismatches %0d, checks %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        rd_q = o_wb_dat;
        if (n >= 50) fail_count++;
        {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        wb(1'b0, a, 32'h0);
        check(rd_q & m, e);
    endtask : rd
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            wb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end while (rd_q[b] !== 1'b1 && n < 400);
        check(rd_q[b], 1'b1);
    endtask : wait_flag
    initial begin
        #300000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} = '0;
        {i_nrst, ack_en, hold_low, fail_count, checked} = '0;
        i_wb_sel = 4'hF;
        ack_en = 1'b1;
        seed = 32'h0001_5282;
        repeat (10) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        rd(ADDR_STATUS, 32'h1, 32'h3);
        rd(ADDR_TIMING, {24'h0, DIV_RST}, 32'hFF);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr(ADDR_WMARK, seed);
            rd(ADDR_WMARK, wm(seed), 32'hFFFF_FFFF);
        end
        wr(ADDR_WMARK, 32'h0003_0002);
        wr(ADDR_CTRL, 32'h4);
        for (int n = 0; n <= 5; n++) begin
            rd(ADDR_FCNT, (n > 4) ? 4 : n, 32'h7);
            rd(ADDR_STATUS, n <= 2, 32'h1);
            check(o_tx_dma_req, n <= 2);
            check(o_rx_dma_req, 1'b0);
            wr(ADDR_TXDATA, 32'hA0 + n);
        end
        wr(ADDR_TIMING, 32'h2);
        wr(ADDR_CTRL, 32'h1);
        wait_flag(ST_PKTEND);
        wait_flag(ST_STOP);
        rd(ADDR_STATUS, 32'h1303, 32'h7F03);
        rd(ADDR_FCNT, 32'h0004_0000, 32'h0007_0007);
        wr(ADDR_CTRL, 32'h8);
        check({o_tx_dma_req, o_rx_dma_req}, 2'b01);
        for (int k = 0; k < 4; k++)
            rd(ADDR_RXDATA, 32'hA0 + k, 32'hFF);
        rd(ADDR_RXDATA, 32'h0, 32'hFFFF_FFFF);
        wr(ADDR_STATUS, 32'h0);
        rd(ADDR_STATUS, 32'h1301, 32'h7F03);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ADDR_STATUS, 32'h1, 32'h7F03);
        wr(ADDR_IEN, 32'hFFFF_FFFF);
        rd(ADDR_IEN, {6'h0, IEN_MASK}, 32'hFFFF_FFFF);
        check(o_irq, 1'b1);
        wr(ADDR_IEN, 32'h100);
        rd(ADDR_IEN, 32'h100, 32'hFFFF_FFFF);
        check(o_irq, 1'b0);
        ack_en = 1'b0;
        seed = lfsr(seed);
        wr(ADDR_TXDATA, {24'h0, seed[7:0]});
        wr(ADDR_CTRL, 32'h1);
        wait_flag(ST_NACK);
        ack_en = 1'b1;
        wr(ADDR_TMO, 32'h14);
        hold_low = 1'b1;
        wait_flag(ST_STUCK);
        hold_low = 1'b0;
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_TIMING, 32'h40);
        wr(ADDR_TMO, 32'h0);
        wr(ADDR_TXDATA, 32'h5A);
        wr(ADDR_CTRL, 32'h1);
        repeat (60) @(posedge i_sys_clk);
        rd(ADDR_STATUS, 32'h0100_0000, 32'h0100_0000);
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_STATUS, 32'h0, 32'h0100_0000);
        wr(ADDR_CTRL, 32'h2);
        rd(ADDR_IEN, 32'h0, 32'hFFFF_FFFF);
        rd(ADDR_TIMING, {24'h0, DIV_RST}, 32'hFFFF_FFFF);
        wr(8'h80, 32'hFFFF_FFFF);
        rd(8'h80, 32'h0, 32'hFFFF_FFFF);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
